// ===== core/wseq_engine.sv
// eight-slot waveform sequencer with main repeat and open-loop offsets
// Behaviour
// - whole sequence replays main-repeat-field extra times
// - pass ends at zero identifier or slot eight
// - zero plays once; one to six repeat
// - seven repeats forever until trigger or go-clear
// - overdrive portion adjusted by overdrive offset
// - peak voltage sample counts as overdrive
// - offsets apply only in open loop
// - offsets signed, counted in sample periods
// - positive sustain adjusted by signed offset
// - other positive samples are positive sustain
// - negative sustain adjusted by signed offset
// - other negative samples are negative sustain
// - each slot plays one to four times
`timescale 1ns/1ps
`include "wseq_defines.svh"
module wseq_engine (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic go,
  input wire logic trig_pin,
  input wire wseq_pkg::slot_ids_t slot_id,
  input wire wseq_pkg::slot_loops_t slot_repeat_count,
  input wire logic effect_done,
  output logic [6:0] effect_id,
  output logic effect_start,
  output logic busy,
  input wire logic open_loop,
  input wire logic sample_valid,
  input wire logic signed [7:0] sample,
  input wire logic signed [7:0] sample_peak,
  input wire logic [7:0] sample_hold,
  output logic adj_valid,
  output wseq_pkg::sample_class_t adj_class,
  output logic [8:0] adj_hold
);
  import wseq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] repeat_reg_q, repeat_reg_d;
  logic [7:0] od_q, od_d, pos_q, pos_d, neg_q, neg_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] sequence_repeat_count;

  always_comb begin
    repeat_reg_d = repeat_reg_q;
    od_d = od_q;
    pos_d = pos_q;
    neg_d = neg_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      case (reg_addr)
        `WSEQ_ADDR_REPEAT: repeat_reg_d = reg_wdata;
        `WSEQ_ADDR_OD_OFF: od_d = reg_wdata;
        `WSEQ_ADDR_POS_OFF: pos_d = reg_wdata;
        `WSEQ_ADDR_NEG_OFF: neg_d = reg_wdata;
        default: repeat_reg_d = repeat_reg_q;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `WSEQ_ADDR_REPEAT: rdata_d = repeat_reg_q;
        `WSEQ_ADDR_OD_OFF: rdata_d = od_q;
        `WSEQ_ADDR_POS_OFF: rdata_d = pos_q;
        `WSEQ_ADDR_NEG_OFF: rdata_d = neg_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      repeat_reg_q <= `WSEQ_RST_REG;
      od_q <= `WSEQ_RST_REG;
      pos_q <= `WSEQ_RST_REG;
      neg_q <= `WSEQ_RST_REG;
      rdata_q <= 8'h00;
    end else begin
      repeat_reg_q <= repeat_reg_d;
      od_q <= od_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
      rdata_q <= rdata_d;
    end
  end

  assign sequence_repeat_count = repeat_reg_q[`WSEQ_REPEAT_MSB:`WSEQ_REPEAT_LSB];
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // trigger pin synchroniser and start/stop events
  logic trig_s1_q, trig_s2_q, trig_s3_q, go_prev_q;
  logic start_req, stop_req, trig_rise;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
      go_prev_q <= 1'b0;
    end else begin
      trig_s1_q <= trig_pin;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      go_prev_q <= go;
    end
  end

  assign trig_rise = trig_s2_q && !trig_s3_q;
  assign start_req = trig_rise || (go && !go_prev_q);
  // same trigger that starts an idle engine stops a running one, but only while it waits in ST_WAIT
  assign stop_req = trig_rise || (!go && go_prev_q);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  seq_state_t state_q, state_d;
  logic [2:0] slot_q, slot_d, pass_q, pass_d;
  logic [1:0] rep_q, rep_d;
  logic [6:0] id_q, id_d;
  logic start_q, start_d;
  logic slot_more, pass_last, pass_more;

  assign slot_more = rep_q != slot_repeat_count[slot_q];
  assign pass_last = (slot_q == `WSEQ_LAST_SLOT) ||
                     (slot_id[slot_q + 3'h1] == `WSEQ_SLOT_IDLE);
  assign pass_more = (sequence_repeat_count == `WSEQ_REPEAT_FOREVER) ||
                     (pass_q != sequence_repeat_count);

  always_comb begin
    state_d = state_q;
    slot_d = slot_q;
    pass_d = pass_q;
    rep_d = rep_q;
    id_d = id_q;
    start_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start_req && slot_id[0] != `WSEQ_SLOT_IDLE) begin
          state_d = ST_WAIT;
          slot_d = 3'h0;
          pass_d = 3'h0;
          rep_d = 2'h0;
          id_d = slot_id[0];
          start_d = 1'b1;
        end
      end
      ST_PLAY: begin
        id_d = slot_id[slot_q];
        start_d = 1'b1;
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (stop_req) begin
          state_d = ST_IDLE;
        end else if (effect_done) begin
          if (slot_more) begin
            rep_d = rep_q + 2'h1;
            state_d = ST_PLAY;
          end else if (!pass_last) begin
            rep_d = 2'h0;
            slot_d = slot_q + 3'h1;
            state_d = ST_PLAY;
          end else if (pass_more) begin
            rep_d = 2'h0;
            slot_d = 3'h0;
            // forever mode keeps the pass count parked so it never wraps
            if (sequence_repeat_count != `WSEQ_REPEAT_FOREVER) begin
              pass_d = pass_q + 3'h1;
            end
            state_d = ST_PLAY;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      slot_q <= 3'h0;
      pass_q <= 3'h0;
      rep_q <= 2'h0;
      id_q <= 7'h00;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      slot_q <= slot_d;
      pass_q <= pass_d;
      rep_q <= rep_d;
      id_q <= id_d;
      start_q <= start_d;
    end
  end

  assign effect_id = id_q;
  assign effect_start = start_q;
  assign busy = state_q != ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // duration adjuster
  wave_if w ();
  assign w.in_valid = sample_valid;
  assign w.sample = sample;
  assign w.peak = sample_peak;
  assign w.hold = sample_hold;
  assign w.open_loop = open_loop;
  assign w.od_off = od_q;
  assign w.pos_off = pos_q;
  assign w.neg_off = neg_q;
  assign adj_valid = w.out_valid;
  assign adj_class = w.cls;
  assign adj_hold = w.adj_hold;

  wseq_adjust u_adjust (
    .clk(clk),
    .rst_b(rst_b),
    .w(w.adj)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_pass_end;
    state_q == ST_WAIT && effect_done && !stop_req && !slot_more && pass_last;
  endsequence

  property p_first_slot;
    (state_q == ST_IDLE && start_req && slot_id[0] != 7'h00)
      |=> (effect_start && effect_id == $past(slot_id[0]) && busy);
  endproperty
  a_first_slot: assert property (p_first_slot) else $error("first slot not started");

  property p_zero_id;
    (state_q == ST_IDLE && slot_id[0] == 7'h00) |=> !busy;
  endproperty
  a_zero_id: assert property (p_zero_id) else $error("empty sequence played");

  property p_play_once;
    (s_pass_end and (sequence_repeat_count == 3'h0)) |=> !busy;
  endproperty
  a_play_once: assert property (p_play_once) else $error("single pass did not end");

  property p_replay;
    (s_pass_end and (sequence_repeat_count != 3'h7) and (pass_q < sequence_repeat_count))
      |=> ##1 (effect_start && effect_id == slot_id[0]);
  endproperty
  a_replay: assert property (p_replay) else $error("repeat pass missing");

  property p_forever;
    (s_pass_end and (sequence_repeat_count == 3'h7)) |=> busy ##1 effect_start;
  endproperty
  a_forever: assert property (p_forever) else $error("forever mode stopped");

  property p_stop;
    (busy && stop_req && state_q == ST_WAIT) |=> (!busy && !effect_start);
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");

  property p_slot_repeat;
    (state_q == ST_WAIT && effect_done && !stop_req && slot_more)
      |=> ##1 (effect_start && effect_id == $past(effect_id, 2));
  endproperty
  a_slot_repeat: assert property (p_slot_repeat) else $error("slot repeat wrong");
endmodule

// ===== core/wseq_defines.svh
// register offsets, reset values, field positions and counts of the sequence engine
`ifndef WSEQ_DEFINES_SVH
`define WSEQ_DEFINES_SVH
`define WSEQ_ADDR_REPEAT 8'h19
`define WSEQ_ADDR_OD_OFF 8'h1A
`define WSEQ_ADDR_POS_OFF 8'h1B
`define WSEQ_ADDR_NEG_OFF 8'h1C
`define WSEQ_RST_REG 8'h00
`define WSEQ_REPEAT_MSB 2
`define WSEQ_REPEAT_LSB 0
`define WSEQ_REPEAT_FOREVER 3'h7
`define WSEQ_LAST_SLOT 3'h7
`define WSEQ_SLOT_IDLE 7'h00
`endif

// ===== core/wseq_pkg.sv
// types shared by the sequence engine and its duration adjuster
package wseq_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_PLAY, ST_WAIT} seq_state_t;
  typedef enum logic [1:0] {CLS_ZERO, CLS_OVERDRIVE, CLS_POS, CLS_NEG} sample_class_t;
  typedef logic [7:0][6:0] slot_ids_t;
  typedef logic [7:0][1:0] slot_loops_t;
endpackage

// ===== core/wave_if.sv
// sample stream and offset settings between engine top and adjuster
`timescale 1ns/1ps
interface wave_if;
  import wseq_pkg::*;
  logic in_valid;
  logic signed [7:0] sample;
  logic signed [7:0] peak;
  logic [7:0] hold;
  logic open_loop;
  logic [7:0] od_off;
  logic [7:0] pos_off;
  logic [7:0] neg_off;
  logic out_valid;
  sample_class_t cls;
  logic [8:0] adj_hold;
  modport ctl (output in_valid, sample, peak, hold, open_loop, od_off, pos_off, neg_off,
               input out_valid, cls, adj_hold);
  modport adj (input in_valid, sample, peak, hold, open_loop, od_off, pos_off, neg_off,
               output out_valid, cls, adj_hold);
endinterface

// ===== core/wseq_adjust.sv
// classifies library samples and applies signed duration offsets
`timescale 1ns/1ps
`include "wseq_defines.svh"
module wseq_adjust (
  input wire logic clk,
  input wire logic rst_b,
  wave_if.adj w
);
  import wseq_pkg::*;
  sample_class_t cls_d, cls_q;
  logic [8:0] adj_d, adj_q;
  logic valid_d, valid_q;
  logic [7:0] off;
  logic signed [9:0] sum;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    valid_d = w.in_valid;
    cls_d = cls_q;
    adj_d = adj_q;
    off = 8'h00;
    if (w.sample == w.peak && w.sample > 8'sh00) begin
      cls_d = CLS_OVERDRIVE;
      off = w.od_off;
    end else if (w.sample > 8'sh00) begin
      cls_d = CLS_POS;
      off = w.pos_off;
    end else if (w.sample < 8'sh00) begin
      cls_d = CLS_NEG;
      off = w.neg_off;
    end else begin
      cls_d = CLS_ZERO;
    end
    // offset counts in sample periods, read as two's complement
    sum = $signed({2'b00, w.hold}) + $signed({{2{off[7]}}, off});
    if (!w.open_loop) begin
      adj_d = {1'b0, w.hold};
    end else if (sum[9]) begin
      adj_d = 9'h000;
    end else begin
      adj_d = sum[8:0];
    end
    if (!w.in_valid) begin
      cls_d = cls_q;
      adj_d = adj_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cls_q <= CLS_ZERO;
      adj_q <= 9'h000;
      valid_q <= 1'b0;
    end else begin
      cls_q <= cls_d;
      adj_q <= adj_d;
      valid_q <= valid_d;
    end
  end

  assign w.cls = cls_q;
  assign w.adj_hold = adj_q;
  assign w.out_valid = valid_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_closed_loop_plain;
    (w.in_valid && !w.open_loop) |=> (w.adj_hold == {1'b0, $past(w.hold)});
  endproperty
  a_closed_loop_plain: assert property (p_closed_loop_plain) else $error("closed loop altered");

  property p_od_class;
    (w.in_valid && w.sample == w.peak && w.sample > 8'sh00) |=> (w.cls == CLS_OVERDRIVE);
  endproperty
  a_od_class: assert property (p_od_class) else $error("peak not overdrive");

  property p_pos_class;
    (w.in_valid && w.sample != w.peak && w.sample > 8'sh00) |=> (w.cls == CLS_POS);
  endproperty
  a_pos_class: assert property (p_pos_class) else $error("positive misclassed");

  property p_neg_class;
    (w.in_valid && w.sample < 8'sh00) |=> (w.cls == CLS_NEG);
  endproperty
  a_neg_class: assert property (p_neg_class) else $error("negative misclassed");

  property p_saturate;
    (w.in_valid && w.open_loop && sum[9]) |=> (w.adj_hold == 9'h000 && w.out_valid);
  endproperty
  a_saturate: assert property (p_saturate) else $error("shortening wrapped");

  property p_od_offset;
    (w.in_valid && w.open_loop && cls_d == CLS_OVERDRIVE && !sum[9])
      |=> (w.adj_hold == $past(w.hold) + {{1{$past(w.od_off[7])}}, $past(w.od_off)});
  endproperty
  a_od_offset: assert property (p_od_offset) else $error("overdrive offset wrong");
endmodule

// ===== tb/wseq_engine_tb.sv
// self-checking bench for the sequence engine and duration adjuster
`timescale 1ns/1ps
`include "wseq_defines.svh"
module wseq_engine_tb;
  import wseq_pkg::*;
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, go = 0, trig_pin = 0, effect_done = 0;
  logic open_loop = 0, sample_valid = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, sample_hold = 0, reg_rdata;
  logic signed [7:0] sample = 0, sample_peak = 0;
  slot_ids_t slot_id = '0;
  slot_loops_t slot_repeat_count = '0;
  logic [6:0] effect_id;
  logic effect_start, busy, adj_valid;
  sample_class_t adj_class;
  logic [8:0] adj_hold;
  int n_errors = 0, comparisons = 0, cycles = 0, cnt = 0, done_dly = 3;
  logic [6:0] got[$], exp_q[$];
  logic [7:0] mdl[4];
  wseq_engine dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .go(go),
    .trig_pin(trig_pin), .slot_id(slot_id), .slot_repeat_count(slot_repeat_count),
    .effect_done(effect_done), .effect_id(effect_id), .effect_start(effect_start), .busy(busy),
    .open_loop(open_loop), .sample_valid(sample_valid), .sample(sample),
    .sample_peak(sample_peak), .sample_hold(sample_hold), .adj_valid(adj_valid),
    .adj_class(adj_class), .adj_hold(adj_hold));
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // player stand-in: long delay keeps stops inside the wait for completion
  always @(posedge clk) begin
    if (effect_start === 1'b1) begin
      got.push_back(effect_id);
      cnt = done_dly;
    end else if (cnt > 0) begin
      cnt--;
    end
    effect_done <= (cnt == 1);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e, input string what);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t %s got %0h exp %0h", $time, what, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    @(negedge clk) chk({4'h0, reg_rdata}, {4'h0, e}, "register read");
  endtask
  function automatic logic [11:0] exp_adj(input logic signed [7:0] s, input logic signed [7:0] pk,
      input logic [7:0] h, input logic ol);
    int v;
    sample_class_t c;
    logic signed [7:0] off;
    off = 8'h00;
    c = CLS_ZERO;
    if (s > 0 && s == pk) begin
      c = CLS_OVERDRIVE;
      off = mdl[1];
    end else if (s > 0) begin
      c = CLS_POS;
      off = mdl[2];
    end else if (s < 0) begin
      c = CLS_NEG;
      off = mdl[3];
    end
    v = int'(h) + (ol ? int'(off) : 0);
    if (v < 0) v = 0;
    return {1'b1, c, 9'(v)};
  endfunction
  function automatic void build();
    exp_q.delete();
    for (int s = 0; s < 8; s++) begin
      if (slot_id[s] == 7'h00) break;
      for (int k = 0; k <= int'(slot_repeat_count[s]); k++) exp_q.push_back(slot_id[s]);
    end
  endfunction
  task automatic trig_pulse();
    @(posedge clk) trig_pin <= 1'b1;
    repeat (4) @(posedge clk);
    trig_pin <= 1'b0;
  endtask
  // how: 0 runs out, 1 stopped by go fall, 2 started and stopped by the pin
  task automatic play(input logic [2:0] rep, input int how);
    int n;
    got.delete();
    wr(`WSEQ_ADDR_REPEAT, {5'($urandom), rep});
    build();
    if (how == 2) trig_pulse();
    else @(posedge clk) go <= 1'b1;
    repeat (2) @(negedge clk);
    chk({11'h0, busy}, 12'h1, "busy after start");
    if (how != 0) begin
      // long enough for more than one full pass of four plays per slot
      repeat (1500) @(posedge clk);
      n = 0;
      while (effect_start !== 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      if (how == 1) @(posedge clk) go <= 1'b0;
      else trig_pulse();
    end
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk({11'h0, busy}, 12'h0, "sequencer idle");
    if (how != 0) chk({11'h0, n < 40}, 12'h1, "stop latency");
    @(posedge clk) go <= 1'b0;
    if (how == 0) chk(12'(got.size()), 12'((rep + 1) * exp_q.size()), "effect count");
    else chk({11'h0, got.size() > exp_q.size()}, 12'h1, "endless replay");
    for (int i = 0; i < got.size(); i++)
      chk({5'h0, got[i]}, {5'h0, exp_q[i % exp_q.size()]}, "effect order");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] adr[4];
    logic [7:0] h;
    slot_ids_t ids;
    slot_loops_t loops;
    void'($urandom(32'h6282));
    adr = '{`WSEQ_ADDR_REPEAT, `WSEQ_ADDR_OD_OFF, `WSEQ_ADDR_POS_OFF, `WSEQ_ADDR_NEG_OFF};
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int r = 0; r < 4; r++) rd_chk(adr[r], `WSEQ_RST_REG);
    for (int k = 0; k < 3; k++) begin
      for (int r = 0; r < 4; r++) begin
        mdl[r] = 8'($urandom);
        wr(adr[r], mdl[r]);
      end
      wr(8'h1D, 8'hA5);
      for (int r = 0; r < 4; r++) rd_chk(adr[r], mdl[r]);
      rd_chk(8'(k * 8'h7F + 8'h18 * (k == 0)), 8'h00);
    end
    // duration adjuster, saturation corners first
    for (int i = 0; i < 40; i++) begin
      for (int r = 1; r < 4; r++) begin
        mdl[r] = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom);
        wr(adr[r], mdl[r]);
      end
      for (int j = 0; j < 4; j++) begin
        h = (i == 0) ? 8'h01 : (i == 1) ? 8'hFF : 8'($urandom);
        @(posedge clk) begin
          sample <= 8'($urandom);
          sample_peak <= (j < 2) ? 8'($urandom_range(1, 127)) : 8'($urandom);
          sample_hold <= h;
          open_loop <= (j != 3);
          sample_valid <= 1'b1;
        end
        if (j < 2) @(posedge clk) sample <= sample_peak;
        @(posedge clk) sample_valid <= 1'b0;
        @(negedge clk);
        chk({adj_valid, adj_class, adj_hold}, exp_adj(sample, sample_peak, h, open_loop),
          "adjusted sample");
      end
    end
    // a start with an empty first slot is ignored
    @(posedge clk) slot_id <= '0;
    @(posedge clk) go <= 1'b1;
    repeat (4) @(negedge clk);
    chk({11'h0, busy}, 12'h0, "empty sequence start");
    @(posedge clk) go <= 1'b0;
    for (int rep = 0; rep < 7; rep++) begin
      for (int s = 0; s < 8; s++) ids[s] = 7'($urandom_range(1, 127));
      if (rep % 2 == 1) ids[$urandom_range(1, 7)] = 7'h00;
      loops = (rep == 6) ? '1 : 16'($urandom);
      @(posedge clk) begin
        slot_id <= ids;
        slot_repeat_count <= loops;
      end
      play(3'(rep), 0);
    end
    done_dly = 20;
    play(`WSEQ_REPEAT_FOREVER, 1);
    play(`WSEQ_REPEAT_FOREVER, 2);
    give_verdict();
  end
endmodule
